// ===== wiper_host.sv
// two-wire master that drives the wiper position device from a software register port
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "wiper_host_defines.svh"
module wiper_host
  import wiper_host_pkg::*;
#(
  parameter logic [3:0] DEVICE_TYPE = 4'h9, // arbitrary value, set to the real type code
  parameter int NV_WAIT_CYC = `NV_WAIT_CYC
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic busy
);

  // ****************************************************************************
  // constants and helpers
  // ****************************************************************************
  localparam logic [6:0] QTR_LAST = 7'(`QTR_CYC - 1);
  localparam logic [18:0] TMO_LAST = 19'(NV_WAIT_CYC - 1);

  ctl_t s;
  ctl_t next_s;
  sw_req_t req;
  logic sda_s;
  logic tick;
  logic rx_byte;
  logic nv_op;
  logic [1:0] last_byte;

  // device command byte for an operation
  function automatic logic [7:0] cmd_byte(input op_kind_t op, input logic [1:0] sel);
    logic [3:0] opc;
    logic [1:0] rs;
    opc = `OPC_STEP;
    rs = sel;
    unique case (op)
      OP_RD_CNT: opc = `OPC_RD_CNT;
      OP_WR_CNT: opc = `OPC_WR_CNT;
      OP_RD_SET: opc = `OPC_RD_SET;
      OP_WR_SET: opc = `OPC_WR_SET;
      OP_SET2CNT: opc = `OPC_SET2CNT;
      OP_CNT2SET: opc = `OPC_CNT2SET;
      default: opc = `OPC_STEP;
    endcase
    if (op == OP_RD_CNT || op == OP_WR_CNT || op == OP_STEP) begin
      rs = 2'b00; // counter and step commands carry a zero select
    end
    return {opc, rs, 2'b00}; // see [RULE_07]
  endfunction

  // address byte: type code, two straps, fixed zero, last strap
  function automatic logic [7:0] addr_byte(input logic [2:0] strap);
    return {DEVICE_TYPE, strap[2], strap[1], 1'b0, strap[0]}; // see [RULE_17]
  endfunction

  // ****************************************************************************
  // pin synchroniser
  // ****************************************************************************
  sda_sync u_sda_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .async_in(sda_in),
    .sync_out(sda_s)
  );

  // ****************************************************************************
  // derived terms
  // ****************************************************************************
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign tick = (s.qcnt == QTR_LAST);
  // only the third byte of a read command flows from the device
  assign rx_byte = (s.byte_n == 2'd2) && (s.op == OP_RD_CNT || s.op == OP_RD_SET);
  // operations that end in a nonvolatile write
  assign nv_op = (s.op == OP_WR_SET) || (s.op == OP_CNT2SET); // see [RULE_05]
  // last byte index of the current frame
  always_comb begin
    if (s.poll) begin
      last_byte = 2'd0; // see [RULE_18]
    end else if (s.op == OP_SET2CNT || s.op == OP_CNT2SET || s.op == OP_STEP) begin
      last_byte = 2'd1; // see [RULE_12] see [RULE_13] see [RULE_14]
    end else begin
      last_byte = 2'd2; // see [RULE_08] see [RULE_09] see [RULE_10] see [RULE_11]
    end
  end

  // ****************************************************************************
  // next state
  // ****************************************************************************
  always_comb begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;

    // quarter-period timer, idle holds it at zero
    if (s.st == ST_IDLE || tick) begin
      next_s.qcnt = 7'h00;
    end else begin
      next_s.qcnt = 7'(s.qcnt + 7'h01);
    end

    // wait budget for a nonvolatile write while polling
    if (s.poll && !s.tmo_err) begin
      next_s.tmo = 19'(s.tmo + 19'h00001);
      if (s.tmo == TMO_LAST) begin
        next_s.tmo_err = 1'b1; // see [RULE_05]
      end
    end else if (!s.poll) begin
      next_s.tmo = 19'h00000;
    end

    // software writes
    if (req.wr) begin
      unique case (req.addr)
        `REG_CMD: begin
          if (!s.busy) begin
            next_s.op = op_kind_t'(req.wdata[`CMD_OP_LSB +: 3]);
            next_s.sel = req.wdata[`CMD_SEL_LSB +: 2];
            next_s.dir = req.wdata[`CMD_DIR_BIT];
            next_s.busy = 1'b1;
            next_s.nack = 1'b0;
            next_s.tmo_err = 1'b0;
            next_s.poll = 1'b0;
            next_s.steps = s.data;
            next_s.st = ST_START;
            next_s.ph = 2'd0;
            next_s.qcnt = 7'h00;
          end
        end
        `REG_DATA: next_s.data = req.wdata[5:0];
        `REG_ADDR: next_s.strap = req.wdata[2:0];
        default: ;
      endcase
    end

    // software reads, answered one cycle later
    if (req.rd) begin
      unique case (req.addr)
        `REG_CMD: next_s.rdata = {25'h0, s.dir, s.sel, 1'b0, s.op};
        `REG_DATA: next_s.rdata = {26'h0, s.data};
        `REG_ADDR: next_s.rdata = {29'h0, s.strap};
        `REG_STAT: begin
          next_s.rdata[`STAT_BUSY_BIT] = s.busy;
          next_s.rdata[`STAT_NACK_BIT] = s.nack;
          next_s.rdata[`STAT_TMO_BIT] = s.tmo_err;
          next_s.rdata[`STAT_RVAL_LSB +: 6] = s.rval;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // link sequencer, one phase per quarter period
    if (tick) begin
      next_s.ph = 2'(s.ph + 2'd1);
      unique case (s.st)
        ST_IDLE: begin
          next_s.ph = 2'd0;
        end
        // start: data falls while clock is high, then clock falls
        ST_START: begin
          unique case (s.ph)
            2'd0: begin
              next_s.scl = 1'b1;
              next_s.sda_low = 1'b0;
            end
            2'd1: next_s.sda_low = 1'b1;
            2'd2: next_s.scl = 1'b0;
            default: begin
              next_s.st = ST_BYTE;
              next_s.ph = 2'd0;
              next_s.bit_n = 4'd0;
              next_s.byte_n = 2'd0;
              next_s.sh = addr_byte(s.strap);
            end
          endcase
        end
        // one bit per four phases, ninth bit is the acknowledge
        ST_BYTE: begin
          unique case (s.ph)
            2'd0: begin
              next_s.scl = 1'b0;
              if (s.bit_n == 4'd8) begin
                next_s.sda_low = rx_byte; // master acknowledge, see [RULE_08] see [RULE_10]
              end else begin
                next_s.sda_low = rx_byte ? 1'b0 : ~s.sh[7];
              end
            end
            2'd1: next_s.scl = 1'b1;
            2'd2: begin
              if (s.bit_n != 4'd8) begin
                next_s.sh = {s.sh[6:0], sda_s};
              end
            end
            default: begin
              next_s.scl = 1'b0;
              next_s.bit_n = 4'(s.bit_n + 4'd1);
              if (s.bit_n == 4'd7 && rx_byte) begin
                next_s.rval = s.sh[5:0]; // two zero bits then position, msb first
              end
              if (s.bit_n == 4'd8) begin
                next_s.bit_n = 4'd0;
                if (!rx_byte && sda_s) begin
                  // no acknowledge: retry while polling, else report
                  if (!s.poll) begin
                    next_s.nack = 1'b1;
                  end
                  next_s.st = ST_STOP;
                end else if (s.byte_n == last_byte) begin
                  if (s.poll) begin
                    next_s.poll = 1'b0; // write finished, see [RULE_18]
                  end else if (nv_op) begin
                    next_s.poll = 1'b1; // see [RULE_11] see [RULE_13]
                  end
                  next_s.st = (s.op == OP_STEP && !s.poll) ? ST_STEP : ST_STOP;
                end else begin
                  next_s.byte_n = 2'(s.byte_n + 2'd1);
                  if (s.byte_n == 2'd0) begin
                    next_s.sh = cmd_byte(s.op, s.sel);
                  end else begin
                    next_s.sh = {2'b00, s.data}; // see [RULE_09] see [RULE_11]
                  end
                end
              end
            end
          endcase
        end
        // step pulses: data level picks direction during the clock high phase
        ST_STEP: begin
          unique case (s.ph)
            2'd0: begin
              next_s.scl = 1'b0;
              if (s.steps == 6'd0) begin
                next_s.st = ST_STOP; // see [RULE_14]
                next_s.ph = 2'd0;
              end else begin
                next_s.sda_low = ~s.dir; // see [RULE_15] see [RULE_16]
              end
            end
            2'd1: next_s.scl = 1'b1;
            2'd2: ;
            default: begin
              next_s.scl = 1'b0;
              next_s.steps = 6'(s.steps - 6'd1);
            end
          endcase
        end
        // stop: data rises while clock is high
        ST_STOP: begin
          unique case (s.ph)
            2'd0: begin
              next_s.scl = 1'b0;
              next_s.sda_low = 1'b1;
            end
            2'd1: next_s.scl = 1'b1;
            2'd2: next_s.sda_low = 1'b0;
            default: begin
              next_s.ph = 2'd0;
              if (s.poll && !s.tmo_err) begin
                next_s.st = ST_START; // poll with start and address, see [RULE_18]
              end else begin
                next_s.st = ST_IDLE;
                next_s.poll = 1'b0;
                next_s.busy = 1'b0;
              end
            end
          endcase
        end
        default: begin
          next_s.st = ST_IDLE;
          next_s.ph = 2'd0;
          next_s.busy = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************************
  // state register
  // ****************************************************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{st: ST_IDLE, op: OP_RD_CNT, scl: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************************
  // outputs
  // ****************************************************************************
  assign rdata = s.rdata;
  assign scl = s.scl;
  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe = s.sda_low;
  assign busy = s.busy;

endmodule // wiper_host

// ===== wiper_host_defines.svh
// register offsets, field positions, opcodes and timing counts of the wiper host controller
// ****************************************************************************
// Overview of operation
// [RULE_01] device holds wiper position in a 6-bit counter decoded to one of 64 taps
// [RULE_02] device loads the counter from setting register zero at power-up
// [RULE_03] counter is volatile and may differ after power returns
// [RULE_04] four nonvolatile 6-bit setting registers, readable, writable, copyable with counter
// [RULE_05] every setting register change is a nonvolatile write lasting at most 10 ms
// [RULE_06] each setting register holds bits 5 down to 0, general use or wiper value
// [RULE_07] command byte is 4-bit opcode, 2-bit register select, two zero low bits
// [RULE_08] read counter 1001: device returns two zeros and six bits, master acks, stop
// [RULE_09] write counter 1010: master sends two zeros and six bits, device acks, stop
// [RULE_10] read setting 1011 with select: device returns byte, master acks, then stop
// [RULE_11] write setting 1100 with select: data byte acked, stop starts nonvolatile write
// [RULE_12] copy setting to counter 1101: two bytes then stop, counter loads from setting
// [RULE_13] copy counter to setting 1110: two bytes then stop starts nonvolatile write
// [RULE_14] step command 0010: after ack master clocks step pulses then stop ends stepping
// [RULE_15] clock high with data high increments the counter one position
// [RULE_16] clock high with data low decrements the counter one position
// [RULE_17] device acks its address only when all three strap bits match
// [RULE_18] device withholds address ack during nonvolatile write; master polls until ack
// [RULE_19] increment moves toward high terminal, decrement toward low terminal
// [RULE_20] counter saturates at 63 and 0 instead of wrapping
// ****************************************************************************
`ifndef WIPER_HOST_DEFINES_SVH
`define WIPER_HOST_DEFINES_SVH

// ****************************************************************************
// register map of the controller
// ****************************************************************************
`define REG_CMD 8'h00
`define REG_DATA 8'h04
`define REG_STAT 8'h08
`define REG_ADDR 8'h0c

// command register fields
`define CMD_OP_LSB 0
`define CMD_SEL_LSB 4
`define CMD_DIR_BIT 6
// status register fields
`define STAT_BUSY_BIT 0
`define STAT_NACK_BIT 1
`define STAT_TMO_BIT 2
`define STAT_RVAL_LSB 8

// ****************************************************************************
// device opcodes
// ****************************************************************************
`define OPC_RD_CNT 4'h9
`define OPC_WR_CNT 4'ha
`define OPC_RD_SET 4'hb
`define OPC_WR_SET 4'hc
`define OPC_SET2CNT 4'hd
`define OPC_CNT2SET 4'he
`define OPC_STEP 4'h2

// ****************************************************************************
// timing
// ****************************************************************************
`define SYS_CLK_NS 25
`define SCL_PERIOD_NS 5000
`define QTR_CYC ((`SCL_PERIOD_NS / 4) / `SYS_CLK_NS)
`define NV_WRITE_MS 10
`define NV_WAIT_CYC ((`NV_WRITE_MS * 1000000) / `SYS_CLK_NS)

`endif

// ===== wiper_host_pkg.sv
// types shared by the wiper host controller
package wiper_host_pkg;

  // sequencer states, gray along start-byte-step-stop
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BYTE = 3'b011,
    ST_STEP = 3'b010,
    ST_STOP = 3'b110
  } state_t;

  // operation selected in the command register
  typedef enum logic [2:0] {
    OP_RD_CNT = 3'h0,
    OP_WR_CNT = 3'h1,
    OP_RD_SET = 3'h2,
    OP_WR_SET = 3'h3,
    OP_SET2CNT = 3'h4,
    OP_CNT2SET = 3'h5,
    OP_STEP = 3'h6
  } op_kind_t;

  // two-stage synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_t;

  // software port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sw_req_t;

  // whole state of the controller
  typedef struct packed {
    state_t st;
    logic [1:0] ph;
    logic [6:0] qcnt;
    logic [3:0] bit_n;
    logic [1:0] byte_n;
    logic [7:0] sh;
    logic scl;
    logic sda_low;
    logic poll;
    logic [18:0] tmo;
    op_kind_t op;
    logic [1:0] sel;
    logic dir;
    logic [5:0] data;
    logic [5:0] steps;
    logic [2:0] strap;
    logic busy;
    logic nack;
    logic tmo_err;
    logic [5:0] rval;
    logic [31:0] rdata;
  } ctl_t;

endpackage

// ===== sda_sync.sv
// two flip-flop synchroniser for a pin input
`timescale 1ns/100ps
module sda_sync
  import wiper_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);

  sync_t s;
  sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
  end

  // register the stages, released bus level at reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '{s1: 1'b1, s2: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.s2;

endmodule // sda_sync

// ===== wiper_host_checker.sv
// port assertions for the wiper host controller
`timescale 1ns/100ps
module wiper_host_checker
  import wiper_host_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // data line pulled low while the clock is high
  sequence start_seq;
    scl && sda_oe;
  endsequence
  // clock held low for a run of cycles
  sequence low_seq;
    !scl [*8];
  endsequence
  rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (rd && addr == 8'h10 |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  stat_busy_a: assert property (rd && addr == 8'h08 |=> rdata[0] == $past(busy))
    else $error("status busy bit wrong");
  busy_launch_a: assert property (wr && addr == 8'h00 && !busy && wdata[2:0] != 3'h7 |=> busy)
    else $error("command did not start");
  idle_lines_a: assert property (!busy && !$past(busy) |-> scl && !sda_oe)
    else $error("link not idle");
  start_cond_a: assert property ($rose(busy) |-> ##[1:400] start_seq)
    else $error("no start after command");
  scl_low_a: assert property ($fell(scl) |-> low_seq)
    else $error("clock low phase too short");
  pull_in_cmd_a: assert property (sda_oe |-> busy)
    else $error("data line pulled while idle");
endmodule // wiper_host_checker

bind wiper_host wiper_host_checker u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));

// ===== wiper_dev_model.sv
// behavioural model of the wiper position device on the two-wire link
`timescale 1ns/100ps
module wiper_dev_model #(
  parameter logic [3:0] DEV_TYPE = 4'h6, // arbitrary value
  parameter logic [2:0] STRAP = 3'h5,
  parameter int NV_NS = 100000
)
(
  input wire logic scl,
  input wire logic sda,
  output logic dev_oe
);
  logic [5:0] wiper_position_register;
  logic [5:0] stored_setting_register [4];
  logic [7:0] sh, cmd, tx;
  logic act, rdph, stepping, up, nv_busy, pend;
  int nbit, nbyte;
  // power-up recall from the default setting register
  initial begin
    stored_setting_register = '{6'h3d, 6'h11, 6'h22, 6'h33};
    wiper_position_register = stored_setting_register[0];
    {act, rdph, stepping, up, nv_busy, pend, dev_oe} = 7'h0;
    nbit = 0;
    nbyte = 0;
    cmd = 8'h0;
  end
  // start: data falls while the clock is high
  always @(negedge sda) begin
    if (scl) begin
      {act, rdph, stepping} = 3'b100;
      nbit = 0;
      nbyte = 0;
      cmd = 8'h0;
    end
  end
  // stop: data rises while the clock is high; launches stores and copies
  always @(posedge sda) begin
    if (scl && act) begin
      {act, stepping} = 2'b00;
      if (pend) begin
        stored_setting_register[cmd[3:2]] =
          (cmd[7:4] == 4'he) ? wiper_position_register : tx[5:0];
        pend = 1'b0;
        nv_busy = 1'b1;
        nv_busy <= #(NV_NS) 1'b0;
      end else if (cmd[7:4] == 4'hd && nbyte == 2) begin
        wiper_position_register = stored_setting_register[cmd[3:2]];
      end
    end
  end
  // while active, sample the data line at each rising clock edge
  always @(posedge scl) begin
    if (act && stepping) begin
      up = sda;
    end else if (act) begin
      sh = {sh[6:0], sda};
      nbit++;
    end
  end
  // falling clock edge: steps, acknowledges and read data bits
  always @(negedge scl) begin
    if (act && stepping) begin
      if (up && wiper_position_register != 6'h3f) begin
        wiper_position_register++;
      end else if (!up && wiper_position_register != 6'h00) begin
        wiper_position_register--;
      end
    end else if (act && nbit == 8 && !rdph) begin
      dev_oe = (nbyte != 0) || (!nv_busy && sh[7:4] == DEV_TYPE && !sh[1]
        && {sh[3], sh[2], sh[0]} == STRAP);
      act = dev_oe;
      if (nbyte == 1) begin
        cmd = sh;
        tx = {2'b00, (sh[7:4] == 4'h9) ? wiper_position_register
          : stored_setting_register[sh[3:2]]};
        pend = (sh[7:4] == 4'he);
      end
      if (nbyte == 2 && cmd[7:4] == 4'ha) wiper_position_register = sh[5:0];
      if (nbyte == 2 && cmd[7:4] == 4'hc) begin
        tx = sh;
        pend = 1'b1;
      end
    end else if (act && nbit == 9) begin
      nbit = 0;
      nbyte++;
      stepping = (nbyte == 2 && cmd[7:4] == 4'h2);
      rdph = (nbyte == 2 && (cmd[7:4] == 4'h9 || cmd[7:4] == 4'hb));
      dev_oe = rdph && !tx[7];
    end else if (act && rdph) begin
      dev_oe = (nbit < 8) ? !tx[7 - nbit] : 1'b0;
    end
  end
endmodule // wiper_dev_model

// ===== wiper_host_bench.sv
// self-checking bench for the wiper host controller and device model
`timescale 1ns/100ps
module wiper_host_bench;
  logic sys_clk, resetn, wr, rd, scl, sda_out, sda_oe, busy, dev_oe, sda_line;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  int failures, check_count;
  // clock source
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  // data line pulled up unless a party pulls it low
  assign sda_line = !(sda_oe || dev_oe);
  wiper_host #(.DEVICE_TYPE(4'h6), .NV_WAIT_CYC(20000)) DUT (.sys_clk(sys_clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
  wiper_dev_model #(.DEV_TYPE(4'h6), .STRAP(3'h5)) far_end (.scl(scl), .sda(sda_line),
    .dev_oe(dev_oe));
  // ****************************************************************************
  // register port tasks
  // ****************************************************************************
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
  endtask
  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // data word, command word, then wait for the frame to end
  task automatic run_op(input logic [6:0] cmd, input logic [5:0] d);
    int n;
    n = 0;
    bus_wr(8'h04, {26'h0, d});
    bus_wr(8'h00, {25'h0, cmd});
    while (busy !== 1'b0 && n < 40000) begin
      @(posedge sys_clk);
      n++;
    end
    expect_eq({31'h0, busy}, 32'h0);
  endtask
  // read command, then the value seen on the link
  task automatic read_back(input logic [6:0] cmd, input logic [5:0] exp);
    run_op(cmd, 6'h00);
    bus_rd(8'h08, v);
    expect_eq({26'h0, v[13:8]}, {26'h0, exp});
    expect_eq({29'h0, v[2:0]}, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ****************************************************************************
  // tests
  // ****************************************************************************
  initial begin
    {resetn, wr, rd} = 3'b000;
    addr = 8'h00;
    wdata = 32'h0;
    failures = 0;
    check_count = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    bus_wr(8'h0c, 32'h5);
    bus_rd(8'h0c, v);
    expect_eq(v, 32'h5);
    bus_rd(8'h10, v);
    expect_eq(v, 32'h0);
    read_back(7'h00, 6'h3d);
    run_op(7'h46, 6'h03);
    bus_rd(8'h00, v);
    expect_eq(v, 32'h46);
    read_back(7'h00, 6'h3f);
    run_op(7'h01, 6'h01);
    run_op(7'h06, 6'h03);
    run_op(7'h35, 6'h00);
    read_back(7'h32, 6'h00);
    run_op(7'h23, 6'h2a);
    bus_rd(8'h08, v);
    expect_eq({29'h0, v[2:0]}, 32'h0);
    run_op(7'h24, 6'h00);
    read_back(7'h00, 6'h2a);
    bus_wr(8'h0c, 32'h2);
    run_op(7'h00, 6'h00);
    bus_rd(8'h08, v);
    expect_eq({31'h0, v[1]}, 32'h1);
    tally_and_finish();
  end
  // watchdog against a hung link, well above the roughly 65000 cycles the tests need
  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end
endmodule // wiper_host_bench
